//--- bench/field_model.sv
// Field side model: muting lamps and safety output loads
`timescale 1ns/10ps
`default_nettype none

module field_model (
    // Clock
    input wire logic clock,
    // Pins from the block
    input wire logic [3:0] lamp_drive,
    input wire logic [7:0] out_drive,
    // Fault injection from the bench
    input wire logic [3:0] lamp_open,
    input wire logic [7:0] short_high,
    // Sense lines back to the block
    output logic [3:0] lamp_current,
    output logic [7:0] out_readback
);
    // Continuity sense also works while the lamp is off
    always_ff @(posedge clock) begin
        lamp_current <= ~lamp_open;
        out_readback <= out_drive | short_high;
    end
endmodule

`default_nettype wire

//--- bench/out_diag_test.sv
// Self-checking bench for the output diagnostics block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end

module out_diag_test;
    // Short counts keep the run brief
    localparam int unsigned L = 100;
    localparam int unsigned P = 200;
    localparam int unsigned W = 10;
    localparam int unsigned T = 50;
    logic clock = 1'b0;
    logic resetn = 1'b0;
    out_diag_pkg::bus_req_t bus_req = '0;
    logic [31:0] rdata;
    logic [3:0] lamp_drive;
    logic [3:0] lamp_current;
    logic [3:0] lamp_open = 4'h0;
    logic [7:0] out_drive;
    logic [7:0] out_readback;
    logic [7:0] fault_led;
    logic [7:0] short_high = 8'h00;
    logic [31:0] v;
    int num_errors = 0;
    int n_tests = 0;
    int cnt;

    out_diag #(.LAMP_CYC(L), .PERIOD_CYC(P), .PULSE_CYC(W), .LATCH_CYC(T)) dut_u (
        .clock(clock), .resetn(resetn), .bus_req(bus_req), .rdata(rdata),
        .lamp_drive(lamp_drive), .lamp_current(lamp_current),
        .out_drive(out_drive), .out_readback(out_readback), .fault_led(fault_led));

    field_model field_u (
        .clock(clock), .lamp_drive(lamp_drive), .out_drive(out_drive),
        .lamp_open(lamp_open), .short_high(short_high),
        .lamp_current(lamp_current), .out_readback(out_readback));

    always #5 clock = ~clock;

    // ------------------------------------------------------------
    // Bus and helper tasks
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        bus_req.addr <= a;
        bus_req.wdata <= d;
        bus_req.wr <= 1'b1;
        @(posedge clock);
        bus_req.wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock);
        bus_req.addr <= a;
        bus_req.rd <= 1'b1;
        @(posedge clock);
        bus_req.rd <= 1'b0;
        #1 d = rdata;
    endtask

    task automatic st(input logic [31:0] e);
        rd(out_diag_pkg::ADDR_STATUS, v);
        `CHK(v, e)
    endtask

    task automatic cmd(input logic [31:0] d);
        wr(out_diag_pkg::ADDR_OUT_CMD, d);
    endtask

    task automatic cfg(input logic [31:0] d);
        wr(out_diag_pkg::ADDR_CONFIG, d);
    endtask

    task automatic lamp(input logic [31:0] d);
        wr(out_diag_pkg::ADDR_LAMP_CMD, d);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clock);
    endtask

    // Counts the cycles output 0 is driven low in a window one period long
    task automatic pulses();
        cnt = 0;
        repeat (P) begin
            @(posedge clock);
            #1 if (out_drive[0] === 1'b0) cnt++;
        end
    endtask

    task automatic reset_dut();
        resetn <= 1'b0;
        idle(8);
        resetn <= 1'b1;
        idle(1);
    endtask

    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        idle(30000);
        num_errors++;
        summarize();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        reset_dut();
        rd(out_diag_pkg::ADDR_CONFIG, v);
        `CHK(v, 32'h00000010)
        st(32'h000F00FF);
        rd(8'h10, v);
        `CHK(v, 32'h00000000)
        wr(out_diag_pkg::ADDR_STATUS, 32'hFFFFFFFF);
        st(32'h000F00FF);
        $display("reset and bus test done");
        lamp_open <= 4'h1;
        idle(3 * L);
        st(32'h000F00FF);
        lamp(32'h1);
        idle(L - 5);
        st(32'h000F00FF);
        idle(L + 10);
        st(32'h000E00FF);
        lamp(32'h0);
        idle(2 * L);
        st(32'h000E00FF);
        lamp_open <= 4'h0;
        idle(5);
        st(32'h000F00FF);
        lamp_open <= 4'h1;
        lamp(32'h1);
        idle(L - 8);
        lamp(32'h0);
        idle(3);
        lamp(32'h1);
        idle(L - 8);
        st(32'h000F00FF);
        lamp(32'h0);
        lamp_open <= 4'h0;
        $display("lamp test done");
        cmd(32'hFF);
        idle(P);
        pulses();
        `CHK(cnt, W)
        st(32'h000FFFFF);
        cfg(32'h00);
        pulses();
        `CHK(cnt, 0)
        cfg(32'h10);
        short_high <= 8'h04;
        idle(P + 5);
        st(32'h000FFBFB);
        `CHK(fault_led, 8'h04)
        `CHK(out_drive[2], 1'b0)
        short_high <= 8'h00;
        idle(T + 10);
        st(32'h000FFBFB);
        cmd(32'hFB);
        idle(T + 5);
        st(32'h000FFBFF);
        `CHK(fault_led, 8'h00)
        cmd(32'hFF);
        idle(3);
        st(32'h000FFFFF);
        $display("single channel test done");
        cfg(32'h12);
        cmd(32'hFB);
        idle(3);
        st(32'h000FF3FF);
        cmd(32'hFF);
        idle(3);
        st(32'h000FFFFF);
        short_high <= 8'h08;
        idle(P + 5);
        st(32'h000FF3F3);
        short_high <= 8'h00;
        $display("dual channel test done");
        reset_dut();
        cfg(32'h30);
        cmd(32'hFF);
        short_high <= 8'h01;
        idle(P + 5);
        rd(out_diag_pkg::ADDR_STATUS, v);
        `CHK(v[20], 1'b1)
        `CHK(v[15:8], 8'h00)
        `CHK(out_drive, 8'h00)
        `CHK(fault_led, 8'hFF)
        short_high <= 8'h00;
        cmd(32'h00);
        idle(T + 10);
        rd(out_diag_pkg::ADDR_STATUS, v);
        `CHK(v[20], 1'b1)
        reset_dut();
        st(32'h000F00FF);
        $display("sourcing-only test done");
        summarize();
    end
endmodule

`default_nettype wire

//--- core/out_diag.sv
// Muting lamp checks, output pulse testing and fault latching for safety outputs
//
// Operation
// - Lamp check every 3 s while on.
// - Two consecutive failed checks flag lamp bad.
// - First check waits for next interval boundary.
// - Lamp flag reads good after power-up.
// - Bad lamp flagged within 6 s.
// - Open lamp at power-up flagged once on.
// - Replaced lamp restores flag in either state.
// - Lamp flag 0 open, 1 good.
// - Pulse output off 700 us every 600 ms.
// - Detected short forces data and status off.
// - Dual pair energizes only both on, unfaulted.
// - Dual fault turns both channels off.
// - Single fault turns only that channel off.
// - Faulted outputs stay latched off until cleared.
// - Bipolar fault clears after latch time off.
// - Cleared fault drops red indicator, accepts commands.
// - Sourcing-only short cleared by power cycle only.
// - Sourcing-only short forces every output off.
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/10ps
`default_nettype none

module out_diag #(
    parameter int unsigned LAMP_CYC = out_diag_pkg::LAMP_INTERVAL_CYC,
    parameter int unsigned PERIOD_CYC = out_diag_pkg::PULSE_PERIOD_CYC,
    parameter int unsigned PULSE_CYC = out_diag_pkg::PULSE_WIDTH_CYC,
    parameter int unsigned LATCH_CYC = out_diag_pkg::LATCH_TIME_CYC
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Register port
    input wire out_diag_pkg::bus_req_t bus_req,
    output logic [31:0] rdata,
    // Muting lamp test outputs
    output logic [3:0] lamp_drive,
    input wire logic [3:0] lamp_current,
    // Safety outputs
    output logic [7:0] out_drive,
    input wire logic [7:0] out_readback,
    // Indicators
    output logic [7:0] fault_led
);

    localparam int unsigned NO = out_diag_pkg::NUM_OUT;
    localparam int unsigned NP = out_diag_pkg::NUM_PAIR;
    localparam int unsigned NL = out_diag_pkg::NUM_LAMP;

    // Declared first so every assertion below, generate blocks too, sees it
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [7:0] out_cmd;
    logic [3:0] lamp_cmd;
    logic [5:0] config_reg;
    logic [3:0] lamp_status;
    logic [7:0] out_status;
    logic [7:0] energized;
    logic pwr_fault;

    wire sel_out_cmd = bus_req.addr == out_diag_pkg::ADDR_OUT_CMD;
    wire sel_lamp_cmd = bus_req.addr == out_diag_pkg::ADDR_LAMP_CMD;
    wire sel_config = bus_req.addr == out_diag_pkg::ADDR_CONFIG;
    wire sel_status = bus_req.addr == out_diag_pkg::ADDR_STATUS;

    wire [3:0] dual_mode = config_reg[out_diag_pkg::CFG_DUAL_LSB +: 4];
    wire pulse_en = config_reg[out_diag_pkg::CFG_PULSE_EN_BIT];
    wire src_only = config_reg[out_diag_pkg::CFG_SRC_ONLY_BIT];

    logic [31:0] status_word;
    always_comb begin
        status_word = 32'h0000_0000;
        status_word[out_diag_pkg::ST_OUT_STATUS_LSB +: 8] = out_status;
        status_word[out_diag_pkg::ST_OUT_DATA_LSB +: 8] = energized;
        status_word[out_diag_pkg::ST_LAMP_LSB +: 4] = lamp_status;
        status_word[out_diag_pkg::ST_PWR_FAULT_BIT] = pwr_fault;
    end

    wire [31:0] read_mux =
        sel_out_cmd  ? {24'h00_0000, out_cmd} :
        sel_lamp_cmd ? {28'h000_0000, lamp_cmd} :
        sel_config   ? {26'h000_0000, config_reg} :
        sel_status   ? status_word : 32'h0000_0000;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            out_cmd <= 8'h00;
            lamp_cmd <= 4'h0;
            config_reg <= out_diag_pkg::CONFIG_RESET;
        end else if (bus_req.wr) begin
            if (sel_out_cmd) out_cmd <= bus_req.wdata[7:0];
            if (sel_lamp_cmd) lamp_cmd <= bus_req.wdata[3:0];
            if (sel_config) config_reg <= bus_req.wdata[5:0];
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) rdata <= 32'h0000_0000;
        else if (bus_req.rd) rdata <= read_mux;
        else rdata <= 32'h0000_0000;
    end

    // ------------------------------------------------------------
    // Muting lamp checks
    // ------------------------------------------------------------
    logic [31:0] lamp_timer;
    wire lamp_boundary = lamp_timer == 32'(LAMP_CYC - 1);

    // Free-running so a lamp switched on mid-interval waits for the boundary
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) lamp_timer <= 32'h0000_0000;
        else if (lamp_boundary) lamp_timer <= 32'h0000_0000;
        else lamp_timer <= lamp_timer + 32'h0000_0001;
    end

    logic [1:0] fail_cnt [NL];
    logic [3:0] lamp_on_q;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            lamp_drive <= 4'h0;
            lamp_on_q <= 4'h0;
        end else begin
            lamp_drive <= lamp_cmd;
            lamp_on_q <= lamp_drive;
        end
    end

    genvar l;
    generate
        for (l = 0; l < NL; l++) begin : g_lamp
            // Only checked once the lamp was already driven before the boundary
            wire check = lamp_boundary && lamp_on_q[l] && lamp_drive[l];
            wire fail = check && !lamp_current[l];
            always_ff @(posedge clock or negedge resetn) begin
                if (!resetn) begin
                    fail_cnt[l] <= 2'h0;
                    lamp_status[l] <= 1'b1;
                end else if (!lamp_drive[l]) begin
                    fail_cnt[l] <= 2'h0;
                    // Sense current through the cold lamp still proves continuity
                    if (lamp_current[l]) lamp_status[l] <= 1'b1;
                end else if (check && lamp_current[l]) begin
                    fail_cnt[l] <= 2'h0;
                    lamp_status[l] <= 1'b1;
                end else if (fail) begin
                    if (fail_cnt[l] == 2'(out_diag_pkg::LAMP_FAILS_TO_FLAG - 1)) begin
                        lamp_status[l] <= 1'b0;
                    end else begin
                        fail_cnt[l] <= fail_cnt[l] + 2'h1;
                    end
                end
            end

            a_lamp_single_fail: assert property (
                fail && fail_cnt[l] == 2'h0 && lamp_status[l] |=> lamp_status[l])
                else $error("lamp flagged after one failed check");
            a_lamp_second_fail: assert property (
                fail && fail_cnt[l] == 2'h1 |=> !lamp_status[l])
                else $error("lamp not flagged after two failed checks");
            a_lamp_cnt_clear: assert property (
                !lamp_drive[l] ##1 !lamp_drive[l] |-> fail_cnt[l] == 2'h0)
                else $error("fail counter not cleared while off");
            a_lamp_off_open: assert property (
                !lamp_drive[l] && !lamp_current[l] && lamp_status[l] |=> lamp_status[l])
                else $error("lamp flagged without being driven");
            a_lamp_restore: assert property (
                lamp_current[l] && (!lamp_drive[l] || check) |=> lamp_status[l])
                else $error("replaced lamp not restored");
        end
    endgenerate

    a_lamp_reset_good: assert property (
        $rose(resetn) |-> lamp_status == 4'hF)
        else $error("lamp flag not good after reset");

    // ------------------------------------------------------------
    // Output pulse test timing
    // ------------------------------------------------------------
    logic [31:0] pulse_timer;
    wire period_end = pulse_timer == 32'(PERIOD_CYC - 1);
    wire pulse_active = pulse_en && pulse_timer < 32'(PULSE_CYC);
    // Readback judged at the last cycle of the off pulse
    wire pulse_check = pulse_en && pulse_timer == 32'(PULSE_CYC - 1);

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) pulse_timer <= 32'h0000_0000;
        else if (period_end) pulse_timer <= 32'h0000_0000;
        else pulse_timer <= pulse_timer + 32'h0000_0001;
    end

    // ------------------------------------------------------------
    // Fault latching and output evaluation
    // ------------------------------------------------------------
    logic [7:0] fault;
    logic [7:0] eff_fault;
    logic [7:0] next_energized;
    logic [31:0] latch_cnt [NO];

    // Output still high while pulsed off: short to supply or to another output
    wire [7:0] short_seen = pulse_check ? (energized & out_readback) : 8'h00;

    genvar p;
    generate
        for (p = 0; p < NP; p++) begin : g_pair
            wire pair_fault = fault[2*p] || fault[2*p+1];
            wire both_on = out_cmd[2*p] && out_cmd[2*p+1];
            assign eff_fault[2*p] = dual_mode[p] ? pair_fault : fault[2*p];
            assign eff_fault[2*p+1] = dual_mode[p] ? pair_fault : fault[2*p+1];
            assign next_energized[2*p] = !pwr_fault && !eff_fault[2*p] &&
                (dual_mode[p] ? both_on : out_cmd[2*p]);
            assign next_energized[2*p+1] = !pwr_fault && !eff_fault[2*p+1] &&
                (dual_mode[p] ? both_on : out_cmd[2*p+1]);

            a_pair_both_off: assert property (
                dual_mode[p] && (fault[2*p] || fault[2*p+1])
                |=> !energized[2*p] && !energized[2*p+1])
                else $error("dual pair not both off on fault");
            a_pair_needs_both: assert property (
                dual_mode[p] && !(out_cmd[2*p] && out_cmd[2*p+1])
                |=> !energized[2*p] && !energized[2*p+1])
                else $error("dual pair on with one command");
            a_single_only_off: assert property (
                !dual_mode[p] && fault[2*p] && !fault[2*p+1] && out_cmd[2*p+1] && !pwr_fault
                |=> !energized[2*p] && energized[2*p+1])
                else $error("single fault spread to partner");
        end
    endgenerate

    genvar c;
    generate
        for (c = 0; c < NO; c++) begin : g_chan
            // Bipolar outputs: held in safe state for the latch time clears the fault
            wire safe_hold = fault[c] && !src_only && !out_cmd[c];
            wire latch_done = safe_hold && latch_cnt[c] == 32'(LATCH_CYC - 1);
            always_ff @(posedge clock or negedge resetn) begin
                if (!resetn) begin
                    latch_cnt[c] <= 32'h0000_0000;
                    fault[c] <= 1'b0;
                end else begin
                    latch_cnt[c] <= (safe_hold && !latch_done) ?
                        latch_cnt[c] + 32'h0000_0001 : 32'h0000_0000;
                    if (short_seen[c]) fault[c] <= 1'b1;
                    else if (latch_done) fault[c] <= 1'b0;
                end
            end

            sequence s_short_caught;
                short_seen[c] ##1 fault[c];
            endsequence
            sequence s_held_off;
                !out_drive[c] && !out_status[c];
            endsequence
            a_short_latches: assert property (
                short_seen[c] |-> s_short_caught ##1 s_held_off)
                else $error("short not latched off");
            a_fault_stays: assert property (
                fault[c] && !latch_done |=> fault[c])
                else $error("fault dropped before clearing condition");
            a_fault_clears: assert property (
                latch_done && !short_seen[c] |=> !fault[c] ##1 !fault_led[c])
                else $error("fault not cleared after latch time");
            a_src_no_clear: assert property (
                src_only && fault[c] |=> fault[c])
                else $error("sourcing-only fault cleared without power cycle");
        end
    endgenerate

    // Sticky until power cycle; only the reset removes it
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) pwr_fault <= 1'b0;
        else if (src_only && |short_seen) pwr_fault <= 1'b1;
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            energized <= 8'h00;
            out_status <= 8'h00;
            out_drive <= 8'h00;
            fault_led <= 8'h00;
        end else begin
            energized <= next_energized;
            out_status <= ~eff_fault & {8{!pwr_fault}};
            // Pulse drives off for its width while the data stays on
            out_drive <= next_energized & {8{!pulse_active}};
            fault_led <= eff_fault | {8{pwr_fault}};
        end
    end

    a_pulse_drive_off: assert property (
        pulse_active |=> out_drive == 8'h00)
        else $error("output driven during test pulse");
    a_pulse_period: assert property (
        period_end |=> pulse_timer == 32'h0000_0000 ##1 pulse_timer == 32'h0000_0001)
        else $error("pulse period not restarted");
    a_src_all_off: assert property (
        pwr_fault |=> out_drive == 8'h00 && energized == 8'h00 && fault_led == 8'hFF)
        else $error("outputs not all off after sourcing short");
    a_pwr_sticky: assert property (
        pwr_fault |=> pwr_fault)
        else $error("power-cycle fault cleared");
    a_lamp_interval: assert property (
        lamp_boundary |=> lamp_timer == 32'h0000_0000)
        else $error("lamp interval not restarted");

    // ------------------------------------------------------------
    // Drive, status and indicator checks
    // ------------------------------------------------------------
    a_flag_fall_boundary: assert property (
        $past(!lamp_boundary) |-> (~lamp_status & $past(lamp_status)) == 4'h0)
        else $error("lamp flag dropped away from a check");

    a_lamp_flag_rise: assert property (
        (lamp_status & ~$past(lamp_status) & ~$past(lamp_current)) == 4'h0)
        else $error("lamp flag restored without current");

    a_lamp_spacing: assert property (
        lamp_boundary |=> !lamp_boundary)
        else $error("lamp checks too close together");

    a_lamp_drive_cmd: assert property (
        1'b1 |=> lamp_drive == $past(lamp_cmd))
        else $error("lamp drive does not follow command");

    a_energized_cmd: assert property (
        1'b1 |=> (energized & ~$past(out_cmd)) == 8'h00)
        else $error("output energized without command");

    a_single_follow: assert property (
        dual_mode == 4'h0 && eff_fault == 8'h00 && !pwr_fault
        |=> energized == $past(out_cmd))
        else $error("single outputs do not follow command");

    a_drive_energized: assert property (
        (out_drive & ~energized) == 8'h00)
        else $error("pin driven while data off");

    a_status_fault: assert property (
        (out_status & $past(eff_fault)) == 8'h00)
        else $error("status normal on faulted output");

    a_status_good: assert property (
        eff_fault == 8'h00 && !pwr_fault |=> out_status == 8'hFF)
        else $error("status not normal without fault");

    a_led_clear: assert property (
        eff_fault == 8'h00 && !pwr_fault |=> fault_led == 8'h00)
        else $error("red indicator lit without fault");

    a_fault_needs_short: assert property (
        (fault & ~$past(fault) & ~$past(short_seen)) == 8'h00)
        else $error("fault latched without a short");

    a_src_sets_pwr: assert property (
        src_only && short_seen != 8'h00 |=> pwr_fault)
        else $error("sourcing short did not force safe state");

    a_pulse_width: assert property (
        pulse_check |=> !pulse_active)
        else $error("test pulse longer than its width");

    a_pulse_start: assert property (
        period_end && pulse_en && !bus_req.wr |=> pulse_active)
        else $error("test pulse missing at period start");

endmodule

`default_nettype wire

//--- core/out_diag_pkg.sv
// Constants, register map and bus carrier for the output diagnostics block
package out_diag_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLOCK_MHZ = 100;
    localparam int unsigned CYC_PER_MS = CLOCK_MHZ * 1000;
    localparam int unsigned LAMP_INTERVAL_S = 3;
    localparam int unsigned LAMP_INTERVAL_CYC = LAMP_INTERVAL_S * 1000 * CYC_PER_MS;
    localparam int unsigned PULSE_WIDTH_US = 700;
    localparam int unsigned PULSE_WIDTH_CYC = PULSE_WIDTH_US * CLOCK_MHZ;
    localparam int unsigned PULSE_PERIOD_MS = 600;
    localparam int unsigned PULSE_PERIOD_CYC = PULSE_PERIOD_MS * CYC_PER_MS;
    localparam int unsigned LATCH_TIME_MS = 1000;
    localparam int unsigned LATCH_TIME_CYC = LATCH_TIME_MS * CYC_PER_MS;
    localparam int unsigned LAMP_FAILS_TO_FLAG = 2;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int unsigned NUM_OUT = 8;
    localparam int unsigned NUM_PAIR = 4;
    localparam int unsigned NUM_LAMP = 4;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_OUT_CMD = 8'h00;
    localparam logic [7:0] ADDR_LAMP_CMD = 8'h04;
    localparam logic [7:0] ADDR_CONFIG = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;

    localparam int unsigned CFG_DUAL_LSB = 0;
    localparam int unsigned CFG_PULSE_EN_BIT = 4;
    localparam int unsigned CFG_SRC_ONLY_BIT = 5;
    localparam logic [5:0] CONFIG_RESET = 6'h10;

    localparam int unsigned ST_OUT_STATUS_LSB = 0;
    localparam int unsigned ST_OUT_DATA_LSB = 8;
    localparam int unsigned ST_LAMP_LSB = 16;
    localparam int unsigned ST_PWR_FAULT_BIT = 20;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bus_req_t;

endpackage
